// ==== rtl/ecd_pkg.sv ====
// Shared constants for the display command decoder and its host end.
// Assumes both ends run from one 20 MHz aclk.
package ecd_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_NS = 50;

  // Command codes
  localparam logic [7:0] CMD_ENTRY = 8'h11;
  localparam logic [7:0] CMD_WR_MONO = 8'h24;
  localparam logic [7:0] CMD_WR_RED = 8'h26;
  localparam logic [7:0] CMD_RD_RAM = 8'h27;
  localparam logic [7:0] CMD_SENSE = 8'h28;
  localparam logic [7:0] CMD_SENSE_DUR = 8'h29;
  localparam logic [7:0] CMD_PROG_OTP = 8'h2A;
  localparam logic [7:0] CMD_WR_CEV = 8'h2C;
  localparam logic [7:0] CMD_RD_OPT = 8'h2D;
  localparam logic [7:0] CMD_RD_SEL = 8'h41;

  // Frame memory geometry, one bit per pixel
  localparam logic [5:0] X_TOP = 6'h31;
  localparam logic [8:0] Y_TOP = 9'h12B;
  localparam logic [13:0] X_BYTES = 14'h0032;
  localparam int PLANE_BYTES = 15000;

  // Settings and reset values
  localparam logic [2:0] ENTRY_RST = 3'h3;
  localparam int AXIS_BIT = 2;
  localparam logic [7:0] SENSE_DUR_RST = 8'h49;
  localparam logic [7:0] CEV_RST = 8'h00;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  localparam logic [7:0] OTP_SEL_RST = 8'h00;
  localparam logic [7:0] OTP_SEL_DONE = 8'h01;

  // Timing
  localparam int SENSE_UNIT_S = 1;
  localparam int SENSE_SEC_CYCLES = CLK_HZ * SENSE_UNIT_S;
  localparam int OTP_PROG_TIME_US = 100;
  localparam int OTP_PROG_CYCLES = OTP_PROG_TIME_US * 1000 / CLK_NS;
  localparam int SCLK_HALF_NS = 100;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYCLES = 4;

  // Host command FIFO and register map
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = 10;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_RXD = 8'h08;
  localparam int CMD_DC_BIT = 8;
  localparam int CMD_RD_BIT = 9;
  localparam int STAT_BUSY = 0;
  localparam int STAT_FULL = 1;
  localparam int STAT_IDLE = 2;
  localparam int STAT_RXNEW = 3;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/ecd_link_if.sv ====
// Serial host port between the host end and the display decoder.
// Assumes both ends share aclk; sclk is a plain sampled signal.
`timescale 1ns/1ns
interface ecd_link_if;
  logic sclk;
  logic csn;
  logic dc;
  logic rd;
  logic mosi;
  logic miso;
  logic busy;
  modport device (input sclk, input csn, input dc, input rd, input mosi, output miso, output busy);
  modport host (output sclk, output csn, output dc, output rd, output mosi, input miso, input busy);
endinterface

// ==== rtl/ecd_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty are exact.
`timescale 1ns/1ns
module ecd_fifo #(
  parameter int W = ecd_pkg::FIFO_W,
  parameter int DEPTH = ecd_pkg::FIFO_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_ff];

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule // ecd_fifo

// ==== rtl/ecd_device.sv ====
// Display driver end: serial command decoder, frame planes, sensing and OTP.
// Assumes link inputs are synchronous to aclk and sclk idles low.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
module ecd_device #(
  parameter int SEC_CYCLES = ecd_pkg::SENSE_SEC_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  ecd_link_if.device link,
  input wire logic clock_enable_flag,
  input wire logic analog_enable_flag,
  input wire logic [7:0] sensed_voltage_code,
  output logic [7:0] common_electrode_voltage,
  output logic sense_active,
  output logic otp_program_active,
  output logic [7:0] otp_stored_voltage
);
  typedef enum logic [2:0] {
    ECD_IDLE = 3'b001,
    ECD_SENSE = 3'b010,
    ECD_PROG = 3'b100
  } ecd_seq_t;
  ecd_seq_t seq_ff;
  logic sclk_q_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] rx_sh_ff;
  logic [7:0] tx_sh_ff;
  logic [7:0] cur_cmd_ff;
  logic dummy_ff;
  logic [1:0] opt_idx_ff;
  logic [2:0] entry_ff;
  logic plane_sel_ff;
  logic [7:0] dur_ff;
  logic [7:0] cev_ff;
  logic [7:0] otp_cev_ff;
  logic [7:0] otp_sel_ff;
  logic [5:0] x_ff;
  logic [8:0] y_ff;
  logic [7:0] mem_q_ff;
  logic [31:0] tick_ff;
  logic [3:0] sec_ff;
  logic [7:0] mono_mem [ecd_pkg::PLANE_BYTES];
  logic [7:0] red_mem [ecd_pkg::PLANE_BYTES];
  logic rise;
  logic byte_done;
  logic [7:0] rx_byte;
  logic idle;
  logic cmd_take;
  logic dat_take;
  logic rd_done;
  logic adv;
  logic tick_end;
  logic sense_done;
  logic prog_done;
  logic [13:0] addr;
  logic [7:0] rd_src;
  logic [8:0] nxt_x;
  logic [8:0] nxt_y;
  logic x_end;
  logic y_end;
  // Next value of a wrapping counter, up or down
  function automatic logic [8:0] ecd_wrap(input logic [8:0] v, input logic [8:0] top, input logic up);
    return up ? ((v == top) ? 9'h000 : v + 9'h001) : ((v == 9'h000) ? top : v - 9'h001);
  endfunction
  // True when the next step wraps the counter
  function automatic logic ecd_at_end(input logic [8:0] v, input logic [8:0] top, input logic up);
    return up ? (v == top) : (v == 9'h000);
  endfunction
  // Serial byte framing
  assign rise = link.sclk & ~sclk_q_ff & ~link.csn;
  assign byte_done = rise & (bit_cnt_ff == 3'h7);
  assign rx_byte = {rx_sh_ff[6:0], link.mosi};
  assign idle = (seq_ff == ECD_IDLE);
  // Written command and data bytes arriving while busy are dropped; the host is expected to wait
  assign cmd_take = byte_done & ~link.rd & ~link.dc & idle;
  assign dat_take = byte_done & ~link.rd & link.dc & idle;
  assign rd_done = byte_done & link.rd;
  assign link.miso = tx_sh_ff[7];
  assign link.busy = ~idle;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_q_ff <= 1'b0;
      bit_cnt_ff <= 3'h0;
      rx_sh_ff <= 8'h00;
    end else begin
      sclk_q_ff <= link.sclk;
      if (link.csn) begin
        bit_cnt_ff <= 3'h0;
      end else if (rise) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        rx_sh_ff <= rx_byte;
      end
    end
  end
  // Readback shifter reloads between bytes, shifts after each host sample in a read byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sh_ff <= 8'h00;
    end else if (link.csn) begin
      tx_sh_ff <= rd_src;
    end else if (rise && link.rd) begin
      tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
    end
  end
  // Current command; a new command closes any open transfer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_cmd_ff <= 8'h00;
      dummy_ff <= 1'b0;
      opt_idx_ff <= 2'h0;
    end else if (cmd_take) begin
      cur_cmd_ff <= rx_byte;
      dummy_ff <= (rx_byte == ecd_pkg::CMD_RD_RAM);
      opt_idx_ff <= 2'h0;
    end else if (rd_done) begin
      dummy_ff <= 1'b0;
      if (cur_cmd_ff == ecd_pkg::CMD_RD_OPT && opt_idx_ff != 2'h2) begin
        opt_idx_ff <= opt_idx_ff + 2'h1;
      end
    end
  end
  // Settings written by parameter bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      entry_ff <= ecd_pkg::ENTRY_RST;
      plane_sel_ff <= 1'b0;
      dur_ff <= ecd_pkg::SENSE_DUR_RST;
      cev_ff <= ecd_pkg::CEV_RST;
    end else if (sense_done) begin
      cev_ff <= sensed_voltage_code;
    end else if (dat_take) begin
      case (cur_cmd_ff)
        ecd_pkg::CMD_ENTRY: entry_ff <= rx_byte[2:0];
        ecd_pkg::CMD_RD_SEL: plane_sel_ff <= rx_byte[0];
        ecd_pkg::CMD_SENSE_DUR: dur_ff <= rx_byte;
        // Code stored as given; only 08h..78h in steps of 04h are meaningful
        ecd_pkg::CMD_WR_CEV: cev_ff <= rx_byte;
        default: begin
        end
      endcase
    end
  end
  // Frame planes; bits are kept exactly as the host sent them
  always_ff @(posedge aclk) begin
    if (dat_take && cur_cmd_ff == ecd_pkg::CMD_WR_MONO) begin
      mono_mem[addr] <= rx_byte;
    end
    if (dat_take && cur_cmd_ff == ecd_pkg::CMD_WR_RED) begin
      red_mem[addr] <= rx_byte;
    end
  end
  // Registered read keeps the planes in block memory
  always_ff @(posedge aclk) begin
    mem_q_ff <= plane_sel_ff ? red_mem[addr] : mono_mem[addr];
  end

  always_comb begin
    case (cur_cmd_ff)
      ecd_pkg::CMD_RD_RAM: rd_src = dummy_ff ? ecd_pkg::DUMMY_BYTE : mem_q_ff;
      ecd_pkg::CMD_RD_OPT: begin
        case (opt_idx_ff)
          2'h0: rd_src = otp_sel_ff;
          2'h1: rd_src = cev_ff;
          default: rd_src = 8'h00;
        endcase
      end
      default: rd_src = 8'h00;
    endcase
  end
  // Address stepping after each frame data byte written or read
  assign adv = (dat_take && (cur_cmd_ff == ecd_pkg::CMD_WR_MONO || cur_cmd_ff == ecd_pkg::CMD_WR_RED))
             || (rd_done && cur_cmd_ff == ecd_pkg::CMD_RD_RAM && !dummy_ff);
  assign addr = 14'(y_ff * ecd_pkg::X_BYTES + {8'h00, x_ff});
  always_comb begin
    nxt_x = ecd_wrap({3'h0, x_ff}, {3'h0, ecd_pkg::X_TOP}, entry_ff[0]);
    nxt_y = ecd_wrap(y_ff, ecd_pkg::Y_TOP, entry_ff[1]);
    x_end = ecd_at_end({3'h0, x_ff}, {3'h0, ecd_pkg::X_TOP}, entry_ff[0]);
    y_end = ecd_at_end(y_ff, ecd_pkg::Y_TOP, entry_ff[1]);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x_ff <= 6'h00;
      y_ff <= 9'h000;
    end else if (adv) begin
      if (!entry_ff[ecd_pkg::AXIS_BIT]) begin
        x_ff <= nxt_x[5:0];
        if (x_end) begin
          y_ff <= nxt_y;
        end
      end else begin
        y_ff <= nxt_y;
        if (y_end) begin
          x_ff <= nxt_x[5:0];
        end
      end
    end
  end
  // Timed operations
  assign tick_end = (tick_ff == 32'(SEC_CYCLES - 1));
  assign sense_done = (seq_ff == ECD_SENSE) && tick_end && (sec_ff == dur_ff[3:0]);
  assign prog_done = (seq_ff == ECD_PROG) && (tick_ff == 32'(ecd_pkg::OTP_PROG_CYCLES - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_ff <= ECD_IDLE;
      tick_ff <= 32'h00000000;
      sec_ff <= 4'h0;
    end else begin
      case (seq_ff)
        ECD_IDLE: begin
          tick_ff <= 32'h00000000;
          sec_ff <= 4'h0;
          // Sense without both enables would read a dead node, so refuse it
          if (cmd_take && rx_byte == ecd_pkg::CMD_SENSE && clock_enable_flag && analog_enable_flag) begin
            seq_ff <= ECD_SENSE;
          end else if (cmd_take && rx_byte == ecd_pkg::CMD_PROG_OTP && clock_enable_flag) begin
            seq_ff <= ECD_PROG;
          end
        end
        ECD_SENSE: begin
          if (sense_done) begin
            seq_ff <= ECD_IDLE;
          end else if (tick_end) begin
            tick_ff <= 32'h00000000;
            sec_ff <= sec_ff + 4'h1;
          end else begin
            tick_ff <= tick_ff + 32'h00000001;
          end
        end
        ECD_PROG: begin
          if (prog_done) begin
            seq_ff <= ECD_IDLE;
          end else begin
            tick_ff <= tick_ff + 32'h00000001;
          end
        end
        default: seq_ff <= ECD_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      otp_cev_ff <= ecd_pkg::CEV_RST;
      otp_sel_ff <= ecd_pkg::OTP_SEL_RST;
    end else if (prog_done) begin
      otp_cev_ff <= cev_ff;
      otp_sel_ff <= ecd_pkg::OTP_SEL_DONE;
    end
  end

  assign common_electrode_voltage = cev_ff;
  assign otp_stored_voltage = otp_cev_ff;
  assign sense_active = (seq_ff == ECD_SENSE);
  assign otp_program_active = (seq_ff == ECD_PROG);
endmodule // ecd_device

// ==== rtl/ecd_host.sv ====
// Host end: AXI4-Lite registers feed a byte FIFO drained onto the serial port.
// Assumes the device shares aclk and answers on miso after each sclk rise.
`timescale 1ns/1ns
module ecd_host (
  input wire logic aclk,
  input wire logic aresetn,
  ecd_link_if.host link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [3:0] {
    ECD_S_IDLE = 4'b0001,
    ECD_S_LOW = 4'b0010,
    ECD_S_HIGH = 4'b0100,
    ECD_S_GAP = 4'b1000
  } ecd_ser_t;

  ecd_ser_t ser_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [7:0] aw_addr_ff;
  logic [9:0] w_data_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [7:0] tx_sh_ff;
  logic [7:0] rx_sh_ff;
  logic [7:0] rxd_ff;
  logic rx_new_ff;
  logic dc_ff;
  logic rd_ff;
  logic csn_ff;
  logic sclk_ff;
  logic [2:0] bit_ff;
  logic [7:0] cnt_ff;
  logic push;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [9:0] f_out_data;
  logic both;
  logic is_cmd;
  logic half_end;
  logic rx_set;
  logic rx_clr;

  assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_hold_ff & ~bvalid_ff;
  assign both = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  assign is_cmd = (aw_addr_ff == ecd_pkg::REG_CMD);
  // Command writes wait here until the FIFO has room
  assign push = both & is_cmd & f_in_ready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 10'h000;
      bvalid_ff <= 1'b0;
      bresp_ff <= ecd_pkg::RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata[9:0];
      end
      if (both && (f_in_ready || !is_cmd)) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (is_cmd || aw_addr_ff == ecd_pkg::REG_STAT || aw_addr_ff == ecd_pkg::REG_RXD)
                    ? ecd_pkg::RESP_OK : ecd_pkg::RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign rx_clr = s_axi_arvalid & ~rvalid_ff & (s_axi_araddr == ecd_pkg::REG_RXD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= ecd_pkg::RESP_OK;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= ecd_pkg::RESP_OK;
      rdata_ff <= 32'h00000000;
      case (s_axi_araddr)
        ecd_pkg::REG_CMD: rdata_ff <= 32'h00000000;
        ecd_pkg::REG_STAT: begin
          rdata_ff[ecd_pkg::STAT_BUSY] <= link.busy;
          rdata_ff[ecd_pkg::STAT_FULL] <= ~f_in_ready;
          rdata_ff[ecd_pkg::STAT_IDLE] <= ~f_out_valid & (ser_ff == ECD_S_IDLE);
          rdata_ff[ecd_pkg::STAT_RXNEW] <= rx_new_ff;
        end
        ecd_pkg::REG_RXD: rdata_ff <= {24'h000000, rxd_ff};
        default: rresp_ff <= ecd_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  ecd_fifo #(.W(ecd_pkg::FIFO_W), .DEPTH(ecd_pkg::FIFO_DEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data(w_data_ff),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // Never start a byte while the device is busy; it would drop it
  assign f_out_ready = (ser_ff == ECD_S_IDLE) & ~link.busy;
  assign half_end = (cnt_ff == 8'(ecd_pkg::SCLK_HALF_CYCLES - 1));
  assign rx_set = (ser_ff == ECD_S_HIGH) & half_end & (bit_ff == 3'h7) & rd_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_ff <= ECD_S_IDLE;
      csn_ff <= 1'b1;
      sclk_ff <= 1'b0;
      dc_ff <= 1'b0;
      rd_ff <= 1'b0;
      bit_ff <= 3'h0;
      cnt_ff <= 8'h00;
      tx_sh_ff <= 8'h00;
      rx_sh_ff <= 8'h00;
      rxd_ff <= 8'h00;
    end else begin
      case (ser_ff)
        ECD_S_IDLE: begin
          cnt_ff <= 8'h00;
          bit_ff <= 3'h0;
          if (f_out_valid && f_out_ready) begin
            tx_sh_ff <= f_out_data[7:0];
            dc_ff <= f_out_data[ecd_pkg::CMD_DC_BIT];
            rd_ff <= f_out_data[ecd_pkg::CMD_RD_BIT];
            csn_ff <= 1'b0;
            ser_ff <= ECD_S_LOW;
          end
        end
        ECD_S_LOW: begin
          cnt_ff <= half_end ? 8'h00 : cnt_ff + 8'h01;
          if (half_end) begin
            sclk_ff <= 1'b1;
            rx_sh_ff <= {rx_sh_ff[6:0], link.miso};
            ser_ff <= ECD_S_HIGH;
          end
        end
        ECD_S_HIGH: begin
          cnt_ff <= half_end ? 8'h00 : cnt_ff + 8'h01;
          if (half_end) begin
            sclk_ff <= 1'b0;
            if (bit_ff == 3'h7) begin
              csn_ff <= 1'b1;
              ser_ff <= ECD_S_GAP;
              if (rd_ff) begin
                rxd_ff <= rx_sh_ff;
              end
            end else begin
              bit_ff <= bit_ff + 3'h1;
              tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
              ser_ff <= ECD_S_LOW;
            end
          end
        end
        ECD_S_GAP: begin
          // Gap lets the device fetch and reload its next readback byte
          cnt_ff <= cnt_ff + 8'h01;
          if (cnt_ff == 8'(ecd_pkg::GAP_CYCLES - 1)) begin
            ser_ff <= ECD_S_IDLE;
          end
        end
        default: ser_ff <= ECD_S_IDLE;
      endcase
    end
  end

  // New byte wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_new_ff <= 1'b0;
    end else if (rx_set) begin
      rx_new_ff <= 1'b1;
    end else if (rx_clr) begin
      rx_new_ff <= 1'b0;
    end
  end

  assign link.sclk = sclk_ff;
  assign link.csn = csn_ff;
  assign link.dc = dc_ff;
  assign link.rd = rd_ff;
  assign link.mosi = tx_sh_ff[7];
endmodule // ecd_host

// ==== verif/ecd_link_properties.sv ====
// Checker for the serial link: framing, hold and busy relations.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ns
module ecd_link_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sclk,
  input wire logic csn,
  input wire logic dc,
  input wire logic rd,
  input wire logic mosi,
  input wire logic miso,
  input wire logic busy
);
  logic sclk_q_ff;
  logic [3:0] rises_ff;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Rises seen in the open frame
  always_ff @(posedge aclk) begin
    sclk_q_ff <= sclk;
    if (!aresetn || csn) begin
      rises_ff <= 4'h0;
    end else if (sclk && !sclk_q_ff) begin
      rises_ff <= rises_ff + 4'h1;
    end
  end
  sequence first_bit_s;
    (!sclk)[*2] ##1 sclk;
  endsequence
  sequence high_phase_s;
    sclk[*2] ##1 !sclk;
  endsequence
  idle_clock_a: assert property (csn |-> !sclk)
    else $error("sclk high outside a frame");
  frame_start_a: assert property ($fell(csn) |-> first_bit_s)
    else $error("frame does not open with a low phase");
  high_phase_a: assert property ($rose(sclk) |-> high_phase_s)
    else $error("sclk high phase wrong length");
  select_hold_a: assert property (!csn && $past(!csn) |-> $stable(dc))
    else $error("dc moved inside a byte");
  read_hold_a: assert property (!csn && $past(!csn) |-> $stable(rd))
    else $error("rd moved inside a byte");
  mosi_edge_a: assert property (!csn && $past(!csn) && $changed(mosi) |-> $fell(sclk))
    else $error("mosi changed away from a falling sclk");
  byte_bits_a: assert property ($rose(csn) |-> rises_ff == 4'h8)
    else $error("frame closed without eight bits");
  busy_gate_a: assert property ($fell(csn) |-> !$past(busy))
    else $error("frame opened while busy");
  busy_hold_a: assert property ($rose(busy) |-> busy[*8])
    else $error("busy pulse too short");
  miso_shift_a: assert property (!csn && $past(!csn) && $changed(miso) |-> rd && sclk && $past(sclk))
    else $error("miso moved away from a read sclk rise");
endmodule // ecd_link_properties

// ==== verif/epd_ram_common_electrode_voltage_command_decoder_bench.sv ====
// Bench: AXI4-Lite host end drives the decoder across the link.
// Assumes design files and link checker are compiled first.
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module epd_ram_common_electrode_voltage_command_decoder_bench;
  localparam int SEC = 20;
  localparam int LIM = 5000;
  logic aclk, aresetn, clk_en, ana_en, sen, prg;
  logic [7:0] awaddr, araddr, code, cev, otpv;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [9:0] seq [0:60];
  int n_fail, n_compared, n_busy, n_sense, n_prog;
  ecd_link_if lnk();
  ecd_device #(.SEC_CYCLES(SEC)) i_ecd_device (.aclk(aclk), .aresetn(aresetn), .link(lnk.device),
    .clock_enable_flag(clk_en), .analog_enable_flag(ana_en), .sensed_voltage_code(code),
    .common_electrode_voltage(cev), .sense_active(sen), .otp_program_active(prg), .otp_stored_voltage(otpv));
  ecd_host i_ecd_host (.aclk(aclk), .aresetn(aresetn), .link(lnk.host), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ecd_link_properties i_ecd_link_properties (.aclk(aclk), .aresetn(aresetn), .sclk(lnk.sclk),
    .csn(lnk.csn), .dc(lnk.dc), .rd(lnk.rd), .mosi(lnk.mosi), .miso(lnk.miso), .busy(lnk.busy));
  always #25 aclk = ~aclk;
  always @(posedge aclk) if (lnk.busy === 1'b1) n_busy++;
  always @(posedge aclk) if (sen === 1'b1) n_sense++;
  always @(posedge aclk) if (prg === 1'b1) n_prog++;
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    $display("timeout at %0t", $time);
    close_out();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < LIM; k++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (k >= LIM) hang();
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < LIM; k++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (k >= LIM) hang();
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // Waits for empty queue and idle serializer; busy is not read, so only stalls with bytes queued behind them are covered
  task automatic drain();
    int k;
    for (k = 0; k < LIM; k++) begin
      rd(ecd_pkg::REG_STAT, rv);
      if (rv[ecd_pkg::STAT_IDLE] === 1'b1) break;
    end
    if (k >= LIM) hang();
  endtask
  // Entries: bit9 read, bit8 data select, low byte sent or expected
  task automatic run(input int lo, input int hi);
    int i;
    for (i = lo; i <= hi; i++) begin
      wr(ecd_pkg::REG_CMD, {22'h0, seq[i]});
      if (seq[i][ecd_pkg::CMD_RD_BIT]) begin
        drain();
        rd(ecd_pkg::REG_RXD, rv);
        `CHK(rv[7:0], seq[i][7:0])
      end
    end
    drain();
    $display("test %0d..%0d done", lo, hi);
  endtask
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    clk_en = 1'b1;
    ana_en = 1'b1;
    code = 8'h78;
    awaddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    n_fail = 0;
    n_compared = 0;
    n_busy = 0;
    // Decrementing back over written bytes keeps readback address-exact
    seq = '{10'h024, 10'h1A5, 10'h011, 10'h100, 10'h024, 10'h1A5, 10'h041, 10'h100, 10'h027, 10'h300,
      10'h3A5, 10'h011, 10'h103, 10'h026, 10'h15A, 10'h011, 10'h100, 10'h026, 10'h15A, 10'h041,
      10'h101, 10'h027, 10'h300, 10'h35A, 10'h02D, 10'h300, 10'h300, 10'h02C, 10'h164, 10'h02D,
      10'h300, 10'h364, 10'h029, 10'h141, 10'h028, 10'h02D, 10'h300, 10'h378, 10'h02A, 10'h02D,
      10'h301, 10'h378, 10'h028, 10'h02C, 10'h108, 10'h02D, 10'h301, 10'h308,
      10'h011, 10'h106, 10'h024, 10'h1C3, 10'h011, 10'h105, 10'h024, 10'h13C,
      10'h041, 10'h100, 10'h027, 10'h300, 10'h3C3};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK(cev, 8'h00)
    rd(8'h10, rv);
    `CHK(resp, ecd_pkg::RESP_SLVERR)
    run(0, 23);
    run(24, 31);
    `CHK(cev, 8'h64)
    n_busy = 0;
    run(32, 37);
    `CHK(n_busy, 2 * SEC)
    run(38, 41);
    `CHK(otpv, 8'h78)
    `CHK(n_busy, 2 * SEC + ecd_pkg::OTP_PROG_CYCLES)
    ana_en <= 1'b0;
    run(42, 47);
    `CHK(cev, 8'h08)
    `CHK(n_busy, 2 * SEC + ecd_pkg::OTP_PROG_CYCLES)
    run(48, 60);
    `CHK(n_sense, 2 * SEC)
    `CHK(n_prog, ecd_pkg::OTP_PROG_CYCLES)
    close_out();
  end
endmodule // epd_ram_common_electrode_voltage_command_decoder_bench
